// File: design/adc_line_pkg.sv
// constants for the shared-line converter access block
// assumes a single 10 MHz clock and host accesses as one-cycle strobes
package adc_line_pkg;
  // parallel port unit offsets from its base address
  localparam logic [1:0] PORT0_OFS    = 2'h0;
  localparam logic [1:0] PORT1_OFS    = 2'h1;
  localparam logic [1:0] PORT2_OFS    = 2'h2;
  localparam logic [1:0] MODE_OFS     = 2'h3;
  // port 2 bit positions
  localparam int         SEL_BIT      = 0;
  localparam int         DIN_BIT      = 1;
  localparam int         SCLK_BIT     = 2;
  // reset values; the pull-up holds select high
  localparam logic [7:0] PORT2_RST    = 8'h01;
  localparam logic [7:0] PORT_RST     = 8'h00;
  // converter shape
  localparam int         RES_BITS     = 12;
  localparam int         EXT_CHANNELS = 11;
  localparam int         MUX_SOURCES  = 14;
  localparam int         ADDR_BITS    = 4;
  localparam int         FRAME_CLKS   = 12;
  // self-test sources on channels 11..13
  localparam logic [11:0] TEST_MID    = 12'h800;
  localparam logic [11:0] TEST_LOW    = 12'h000;
  localparam logic [11:0] TEST_HIGH   = 12'hfff;
  // timing
  localparam int         CLK_PERIOD_NS = 100;
  localparam int         CONV_TIME_NS  = 10000;
  localparam int         CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         STEP_CYCLES   = (CONV_CYCLES / RES_BITS) < 1 ? 1 : (CONV_CYCLES / RES_BITS);
endpackage : adc_line_pkg

// File: design/sar_core.sv
// successive-approximation engine: one trial bit per step enable
// assumes start_i is a one-cycle pulse; a start while busy is ignored
`timescale 1ns/10ps
`default_nettype none
module sar_core
  import adc_line_pkg::*;
#(
  parameter int STEPS = STEP_CYCLES
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // conversion request
  input  wire logic        start_i,
  input  wire logic [11:0] sample_i,
  // conversion answer
  output logic             busy_o,
  output logic             done_o,
  output logic      [11:0] result_o
);
  logic [11:0] hold_q, hold_d;
  logic [11:0] res_q, res_d;
  logic [11:0] trial_q, trial_d;
  logic [7:0]  div_q, div_d;
  logic        busy_q, busy_d;
  logic        done_q, done_d;
  logic [11:0] guess;

  always_comb begin
    hold_d  = hold_q;
    res_d   = res_q;
    trial_d = trial_q;
    div_d   = div_q;
    busy_d  = busy_q;
    done_d  = 1'b0;
    guess   = res_q | trial_q;
    if (start_i && !busy_q) begin
      // sample-and-hold happens here, no host action needed
      hold_d  = sample_i;
      res_d   = 12'h000;
      trial_d = 12'h800;
      div_d   = 8'h00;
      busy_d  = 1'b1;
    end else if (busy_q) begin
      if (div_q == 8'(STEPS - 1)) begin
        div_d = 8'h00;
        if (guess <= hold_q) begin
          res_d = guess;
        end
        trial_d = trial_q >> 1;
        if (trial_q == 12'h001) begin
          busy_d = 1'b0;
          done_d = 1'b1;
        end
      end else begin
        div_d = div_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      hold_q  <= 12'h000;
      res_q   <= 12'h000;
      trial_q <= 12'h000;
      div_q   <= 8'h00;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      hold_q  <= hold_d;
      res_q   <= res_d;
      trial_q <= trial_d;
      div_q   <= div_d;
      busy_q  <= busy_d;
      done_q  <= done_d;
    end
  end

  assign busy_o   = busy_q;
  assign done_o   = done_q;
  assign result_o = res_q;
endmodule : sar_core
`default_nettype wire

// File: design/serial_adc_shared_line_access.sv
// parallel port unit port 2 driving a serial converter whose output shares a line
// assumes host strobes are synchronous to clk_i and last one cycle
`timescale 1ns/10ps
`default_nettype none
module serial_adc_shared_line_access
  import adc_line_pkg::*;
(
  // clock and reset
  input  wire logic                             clk_i,
  input  wire logic                             reset_i,
  // host access to the parallel port unit
  input  wire logic [1:0]                       port_addr_i,
  input  wire logic [7:0]                       port_wdata_i,
  input  wire logic                             port_wr_i,
  input  wire logic                             port_rd_i,
  output logic      [7:0]                       port_rdata_o,
  // other port lines
  output logic      [7:0]                       port0_o,
  output logic      [7:0]                       port1_o,
  // analog inputs, channel n at bits n*12 +: 12
  input  wire logic [EXT_CHANNELS*RES_BITS-1:0] analog_in_i,
  // eeprom pulling the shared line low
  input  wire logic                             eeprom_drive_low_i,
  // converter lines
  output logic                                  converter_select_line_o,
  output logic                                  converter_serial_in_line_o,
  output logic                                  converter_serial_clock_line_o,
  output logic                                  converter_return_o,
  output logic                                  converter_return_oe_o,
  output logic                                  shared_serial_return_line_o,
  output logic                                  end_of_conversion_o
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [11:0] mux_pick(input logic [3:0] ch,
                                           input logic [EXT_CHANNELS*RES_BITS-1:0] ain);
    logic [11:0] v;
    v = 12'h000;
    if (ch < 4'(EXT_CHANNELS)) begin
      v = ain[ch*RES_BITS +: RES_BITS];
    end else if (ch == 4'hb) begin
      v = TEST_MID;
    end else if (ch == 4'hc) begin
      v = TEST_LOW;
    end else if (ch == 4'hd) begin
      v = TEST_HIGH;
    end
    return v;
  endfunction : mux_pick

  ////////////////////////////////////////////////////////////////////////////
  // port registers
  logic [7:0] p0_q, p0_d, p1_q, p1_d, p2_q, p2_d, rdata_q, rdata_d;

  always_comb begin
    p0_d    = p0_q;
    p1_d    = p1_q;
    p2_d    = p2_q;
    rdata_d = rdata_q;
    if (port_wr_i && port_addr_i == PORT0_OFS) begin
      p0_d = port_wdata_i;
    end else if (port_wr_i && port_addr_i == PORT1_OFS) begin
      p1_d = port_wdata_i;
    end else if (port_wr_i && port_addr_i == PORT2_OFS) begin
      p2_d = port_wdata_i;
    end else if (port_wr_i && port_addr_i == MODE_OFS) begin
      p0_d = PORT_RST;
      p1_d = PORT_RST;
      p2_d = PORT_RST;
    end
    if (port_rd_i && port_addr_i == PORT0_OFS) begin
      rdata_d = p0_q;
    end else if (port_rd_i && port_addr_i == PORT1_OFS) begin
      rdata_d = p1_q;
    end else if (port_rd_i && port_addr_i == PORT2_OFS) begin
      // read-back lets the host keep other bits when raising select
      rdata_d = p2_q;
    end else if (port_rd_i) begin
      rdata_d = 8'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      p0_q    <= PORT_RST;
      p1_q    <= PORT_RST;
      p2_q    <= PORT2_RST;
      rdata_q <= 8'h00;
    end else begin
      p0_q    <= p0_d;
      p1_q    <= p1_d;
      p2_q    <= p2_d;
      rdata_q <= rdata_d;
    end
  end

  logic sel, din, sclk;
  assign sel  = p2_q[SEL_BIT];
  assign din  = p2_q[DIN_BIT];
  assign sclk = p2_q[SCLK_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // serial frame
  logic        sel_prev_q, sel_prev_d, clk_prev_q, clk_prev_d;
  logic [3:0]  cnt_q, cnt_d, addr_q, addr_d, chan_q, chan_d;
  logic [11:0] out_q, out_d, result_q, result_d;
  logic        start_q, start_d, eoc_q, eoc_d;
  logic        sel_fell, clk_rose, clk_fell;
  logic        sar_busy, sar_done;
  logic [11:0] sar_result;

  always_comb begin
    sel_prev_d = sel;
    clk_prev_d = sclk;
    cnt_d      = cnt_q;
    addr_d     = addr_q;
    chan_d     = chan_q;
    out_d      = out_q;
    result_d   = result_q;
    start_d    = 1'b0;
    eoc_d      = eoc_q;
    sel_fell   = sel_prev_q && !sel;
    clk_rose   = !sel && !sel_fell && !clk_prev_q && sclk;
    clk_fell   = !sel && !sel_fell && clk_prev_q && !sclk;
    if (sel_fell) begin
      cnt_d  = 4'h0;
      addr_d = 4'h0;
      out_d  = result_q;
      eoc_d  = 1'b0;
    end else if (clk_rose && cnt_q < 4'(FRAME_CLKS)) begin
      if (cnt_q < 4'(ADDR_BITS)) begin
        addr_d = {addr_q[2:0], din};
      end
      cnt_d = cnt_q + 4'h1;
      if (cnt_q == 4'(FRAME_CLKS - 1)) begin
        start_d = 1'b1;
        chan_d  = addr_q;
      end
    end else if (clk_fell) begin
      out_d = {out_q[10:0], 1'b0};
    end
    if (sar_done) begin
      result_d = sar_result;
      eoc_d    = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sel_prev_q <= 1'b1;
      clk_prev_q <= 1'b0;
      cnt_q      <= 4'h0;
      addr_q     <= 4'h0;
      chan_q     <= 4'h0;
      out_q      <= 12'h000;
      result_q   <= 12'h000;
      start_q    <= 1'b0;
      eoc_q      <= 1'b0;
    end else begin
      sel_prev_q <= sel_prev_d;
      clk_prev_q <= clk_prev_d;
      cnt_q      <= cnt_d;
      addr_q     <= addr_d;
      chan_q     <= chan_d;
      out_q      <= out_d;
      result_q   <= result_d;
      start_q    <= start_d;
      eoc_q      <= eoc_d;
    end
  end

  sar_core #(.STEPS(STEP_CYCLES)) u_sar (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .start_i  (start_q),
    .sample_i (mux_pick(chan_q, analog_in_i)),
    .busy_o   (sar_busy),
    .done_o   (sar_done),
    .result_o (sar_result)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pins
  assign port_rdata_o                  = rdata_q;
  assign port0_o                       = p0_q;
  assign port1_o                       = p1_q;
  assign converter_select_line_o       = sel;
  assign converter_serial_in_line_o    = din;
  assign converter_serial_clock_line_o = sclk;
  assign converter_return_oe_o         = !sel;
  assign converter_return_o            = out_q[11];
  // pull-up wins when nothing drives low
  assign shared_serial_return_line_o   = converter_return_oe_o ? converter_return_o : !eeprom_drive_low_i;
  assign end_of_conversion_o           = eoc_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  selected_drives_a: assert property (!converter_select_line_o |->
      converter_return_oe_o && shared_serial_return_line_o == out_q[11])
    else $error("converter not driving while selected");
  deselect_release_a: assert property (converter_select_line_o |->
      !converter_return_oe_o && shared_serial_return_line_o == !eeprom_drive_low_i)
    else $error("converter drives while deselected");
  mode_write_low_a: assert property (port_wr_i && port_addr_i == MODE_OFS |=> !converter_select_line_o)
    else $error("mode write left select high");
  pullup_idle_a: assert property (!converter_return_oe_o && !eeprom_drive_low_i |-> shared_serial_return_line_o)
    else $error("idle shared line not high");
  frame_open_a: assert property ($fell(sel) |=> cnt_q == 4'h0 && out_q == $past(result_q))
    else $error("frame did not open on select fall");
  deselect_freeze_a: assert property (sel && $past(sel) |=> $stable(cnt_q) && $stable(addr_q))
    else $error("serial state moved while deselected");
  test_mid_a: assert property (start_q && chan_q == 4'hb |-> ##[1:120] sar_done ##0 sar_result == TEST_MID)
    else $error("self-test mid level wrong");
  conv_bound_a: assert property (start_q && !sar_busy |-> ##[90:120] sar_done)
    else $error("conversion time out of range");
  addr_offset_a: assert property (port_wr_i && port_addr_i == PORT2_OFS |=> p2_q == $past(port_wdata_i))
    else $error("port 2 write not stored");

  frame_cov_c: cover property ($fell(sel) ##[1:300] start_q);
  done_cov_c: cover property (sar_done ##[1:50] $rose(sel));
  eeprom_cov_c: cover property (sel && eeprom_drive_low_i && !shared_serial_return_line_o);
endmodule : serial_adc_shared_line_access
`default_nettype wire

// File: testbench/host_model.sv
// host model: drives the parallel port unit bus and runs converter frames
// assumes one-cycle strobes taken on the rising edge of clk_i
`timescale 1ns/10ps
`default_nettype none
module host_model
  import adc_line_pkg::*;
(
  // clock
  input  wire logic       clk_i,
  // port bus
  output logic      [1:0] port_addr_o,
  output logic      [7:0] port_wdata_o,
  output logic            port_wr_o,
  output logic            port_rd_o,
  input  wire logic [7:0] port_rdata_i,
  // resolved shared return line
  input  wire logic       line_i
);
  initial begin
    port_addr_o = 2'h0;
    port_wdata_o = 8'h00;
    port_wr_o = 1'b0;
    port_rd_o = 1'b0;
  end

  task automatic write_port(input logic [1:0] addr, input logic [7:0] data);
    @(negedge clk_i);
    port_addr_o = addr;
    port_wdata_o = data;
    port_wr_o = 1'b1;
    @(negedge clk_i);
    port_wr_o = 1'b0;
    port_wdata_o = ~data;
  endtask : write_port

  task automatic read_port(input logic [1:0] addr, output logic [7:0] data);
    @(negedge clk_i);
    port_addr_o = addr;
    port_rd_o = 1'b1;
    @(negedge clk_i);
    port_rd_o = 1'b0;
    port_addr_o = ~addr;
    @(negedge clk_i);
    data = port_rdata_i;
  endtask : read_port

  task automatic raise_select();
    logic [7:0] v;
    read_port(PORT2_OFS, v);
    write_port(PORT2_OFS, v | 8'h01);
  endtask : raise_select

  task automatic convert(input logic [3:0] ch, output logic [11:0] res);
    logic [7:0] base;
    logic       din;
    res = 12'h000;
    read_port(PORT2_OFS, base);
    base = base & 8'hf8;
    write_port(PORT2_OFS, base | 8'h01);
    write_port(PORT2_OFS, base);
    for (int i = 0; i < FRAME_CLKS; i++) begin
      din = (i < ADDR_BITS) ? ch[ADDR_BITS-1-i] : 1'b0;
      write_port(PORT2_OFS, base | {6'h00, din, 1'b0});
      write_port(PORT2_OFS, base | 8'h04 | {6'h00, din, 1'b0});
      repeat (2) @(negedge clk_i);
      res = {res[10:0], line_i};
    end
    write_port(PORT2_OFS, base);
    raise_select();
  endtask : convert
endmodule : host_model
`default_nettype wire

// File: testbench/test_serial_adc_shared_line_access.sv
// self-checking bench for the shared-line converter access block
// assumes the package and host_model are compiled first
`timescale 1ns/10ps
`default_nettype none
module test_serial_adc_shared_line_access
  import adc_line_pkg::*;
();
  logic                             clk, reset, port_wr, port_rd, eeprom_low;
  logic [1:0]                       port_addr;
  logic [7:0]                       port_wdata, port_rdata, port0, port1;
  logic [EXT_CHANNELS*RES_BITS-1:0] analog;
  logic                             sel, sin, sclk, ret, ret_oe, line, eoc;
  int                               num_errors = 0;
  int                               n_checks = 0;
  int                               cycles = 0;

  serial_adc_shared_line_access serial_adc_shared_line_access_i (
    .clk_i(clk), .reset_i(reset), .port_addr_i(port_addr), .port_wdata_i(port_wdata),
    .port_wr_i(port_wr), .port_rd_i(port_rd), .port_rdata_o(port_rdata),
    .port0_o(port0), .port1_o(port1), .analog_in_i(analog), .eeprom_drive_low_i(eeprom_low),
    .converter_select_line_o(sel), .converter_serial_in_line_o(sin),
    .converter_serial_clock_line_o(sclk), .converter_return_o(ret),
    .converter_return_oe_o(ret_oe), .shared_serial_return_line_o(line), .end_of_conversion_o(eoc));

  host_model host_model_i (
    .clk_i(clk), .port_addr_o(port_addr), .port_wdata_o(port_wdata), .port_wr_o(port_wr),
    .port_rd_o(port_rd), .port_rdata_i(port_rdata), .line_i(line));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  // hang guard, far above the roughly 1600 cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  function automatic logic [11:0] expect_of(input logic [3:0] ch);
    case (ch)
      4'hb: expect_of = TEST_MID;
      4'hc: expect_of = TEST_LOW;
      4'hd: expect_of = TEST_HIGH;
      4'he, 4'hf: expect_of = 12'h000;
      default: expect_of = analog[ch*RES_BITS +: RES_BITS];
    endcase
  endfunction : expect_of

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset_idle();
    check("select", sel, 1'b1);
    check("return_oe", ret_oe, 1'b0);
    check("line_idle", line, 1'b1);
    check("clock_idle", sclk, 1'b0);
    check("return_idle", ret, 1'b0);
    eeprom_low = 1'b1;
    @(negedge clk);
    check("line_eeprom", line, 1'b0);
    eeprom_low = 1'b0;
    $display("test reset_idle done");
  endtask : test_reset_idle

  task automatic test_mode_write();
    logic [7:0] v;
    host_model_i.write_port(PORT0_OFS, 8'h55);
    host_model_i.write_port(PORT1_OFS, 8'haa);
    host_model_i.read_port(PORT1_OFS, v);
    check("port1_read", v, 8'haa);
    host_model_i.write_port(MODE_OFS, 8'h80);
    repeat (2) @(negedge clk);
    check("select_mode", sel, 1'b0);
    check("port0_cleared", port0, 8'h00);
    check("port1_cleared", port1, 8'h00);
    check("oe_selected", ret_oe, 1'b1);
    check("return_msb", ret, 1'b0);
    host_model_i.read_port(PORT0_OFS, v);
    check("port0_read", v, 8'h00);
    host_model_i.read_port(MODE_OFS, v);
    check("mode_read", v, 8'h00);
    host_model_i.write_port(PORT2_OFS, 8'h02);
    host_model_i.raise_select();
    repeat (2) @(negedge clk);
    check("select_raised", sel, 1'b1);
    check("din_kept", sin, 1'b1);
    check("oe_released", ret_oe, 1'b0);
    $display("test mode_write done");
  endtask : test_mode_write

  task automatic test_conversions();
    logic [3:0]  chans [7] = '{4'hd, 4'hc, 4'hb, 4'h3, 4'ha, 4'he, 4'h0};
    logic [11:0] exp_q, res;
    exp_q = 12'h000;
    for (int k = 0; k < 7; k++) begin
      host_model_i.convert(chans[k], res);
      check("result", res, exp_q);
      repeat (CONV_CYCLES + 20) @(negedge clk);
      check("eoc", eoc, 1'b1);
      exp_q = expect_of(chans[k]);
      for (int j = 0; j < 3 && k == 1; j++) begin
        host_model_i.write_port(PORT2_OFS, 8'h05);
        host_model_i.write_port(PORT2_OFS, 8'h01);
      end
    end
    // last result only shows in the frame after it
    host_model_i.convert(4'hf, res);
    check("result_last", res, exp_q);
    $display("test conversions done");
  endtask : test_conversions

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    eeprom_low = 1'b0;
    for (int n = 0; n < EXT_CHANNELS; n++) begin
      analog[n*RES_BITS +: RES_BITS] = 12'h135 + 12'(n * 263);
    end
    repeat (8) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    test_reset_idle();
    test_mode_write();
    test_conversions();
    tally_and_finish();
  end
endmodule : test_serial_adc_shared_line_access
`default_nettype wire
